/* File: hw/crs_pkg.sv */
`default_nettype none
package crs_pkg;
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned CFG_W           = 8;
	localparam logic [7:0]  CFG_RESET       = 8'h00;
	localparam int unsigned RESET_RELEASE_CLKS = 2;
	localparam int unsigned PON_RESET_MIN_MS = 1;
	localparam int unsigned PON_RESET_MIN_CLKS = (CLK_HZ / 1000) * PON_RESET_MIN_MS;
	localparam int unsigned RESET_MAX_MS    = 10;
	localparam int unsigned RESET_MAX_CLKS  = (CLK_HZ / 1000) * RESET_MAX_MS;
	typedef enum logic [2:0] {
		CRS_RESET,
		CRS_RUN,
		CRS_STOP_GRANT,
		CRS_SLEEP
	} crs_state_t;
endpackage : crs_pkg
`default_nettype wire

/* File: hw/crs_top.sv */
`default_nettype none
module crs_top #(
	parameter int unsigned CFG_W           = crs_pkg::CFG_W,
	parameter int unsigned PON_RESET_CLKS  = crs_pkg::PON_RESET_MIN_CLKS
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             supply_stable_in,
	input  wire logic             bus_reset_n,
	input  wire logic             stop_clock_request_n,
	input  wire logic             sleep_request_n,
	input  wire logic             snoop_req,
	input  wire logic             intr_req,
	input  wire logic [CFG_W-1:0] cfg_pins,
	input  wire logic             mgmt_parts_fitted,
	output var  logic             socket_present_n,
	output var  logic             socket_present_oe,
	output var  logic             mgmt_parts_present,
	output var  logic             mgmt_parts_present_oe,
	output var  logic             bus_out_oe,
	output var  logic             cache_inval,
	output var  logic             in_reset,
	output var  logic             core_clk_en,
	output var  logic             bus_clk_en,
	output var  logic             stop_grant,
	output var  logic             sleeping,
	output var  logic             snoop_ack,
	output var  logic             intr_ack,
	output var  logic [CFG_W-1:0] cfg_q,
	output var  logic             cfg_valid
);
	crs_pkg::crs_state_t state_q;
	crs_pkg::crs_state_t state_d;
	logic                rst_seen_q;
	logic                rst_prev_q;
	logic                armed_q;

	// reset is any of: board reset, supply not stable (local rstn acts in the flops)
	wire held_reset  = !supply_stable_in || !bus_reset_n;
	wire release_edg = rst_prev_q && !held_reset && armed_q;
	wire stop_req    = !stop_clock_request_n;
	wire slp_req     = !sleep_request_n;

	always_comb begin
		state_d = state_q;
		case (state_q)
			crs_pkg::CRS_RESET: begin
				if (release_edg) state_d = crs_pkg::CRS_RUN;
			end
			crs_pkg::CRS_RUN: begin
				if (stop_req) state_d = crs_pkg::CRS_STOP_GRANT;
			end
			crs_pkg::CRS_STOP_GRANT: begin
				if (slp_req) state_d = crs_pkg::CRS_SLEEP;
				else if (!stop_req) state_d = crs_pkg::CRS_RUN;
			end
			crs_pkg::CRS_SLEEP: begin
				if (!slp_req) state_d = crs_pkg::CRS_STOP_GRANT;
			end
			default: state_d = crs_pkg::CRS_RESET;
		endcase
		if (held_reset) state_d = crs_pkg::CRS_RESET;
	end

	wire nxt_run   = (state_d == crs_pkg::CRS_RUN);
	wire nxt_sg    = (state_d == crs_pkg::CRS_STOP_GRANT);
	wire nxt_slp   = (state_d == crs_pkg::CRS_SLEEP);
	wire nxt_rst   = (state_d == crs_pkg::CRS_RESET);
	// sleep answers nothing but reset and sleep release
	wire snoop_d   = snoop_req && (nxt_run || nxt_sg) && !held_reset;
	wire intr_d    = intr_req && (nxt_run || nxt_sg) && !held_reset;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_q    <= crs_pkg::CRS_RESET;
			rst_prev_q <= 1'b1;
			armed_q    <= 1'b0;
		end else begin
			state_q    <= state_d;
			rst_prev_q <= held_reset;
			// release only counts once a reset was seen after supply rose
			armed_q    <= supply_stable_in && (armed_q || !bus_reset_n);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			bus_out_oe  <= 1'b0;
			cache_inval <= 1'b1;
			in_reset    <= 1'b1;
			core_clk_en <= 1'b0;
			bus_clk_en  <= 1'b0;
			stop_grant  <= 1'b0;
			sleeping    <= 1'b0;
			snoop_ack   <= 1'b0;
			intr_ack    <= 1'b0;
		end else begin
			bus_out_oe  <= !nxt_rst;
			cache_inval <= nxt_rst;
			in_reset    <= nxt_rst;
			core_clk_en <= nxt_run;
			bus_clk_en  <= nxt_run || nxt_sg;
			stop_grant  <= nxt_sg;
			sleeping    <= nxt_slp;
			snoop_ack   <= snoop_d;
			intr_ack    <= intr_d;
		end
	end

	// strap sampled by clocked logic at release, never by reset itself
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cfg_q     <= CFG_W'(crs_pkg::CFG_RESET);
			cfg_valid <= 1'b0;
		end else begin
			if (release_edg) cfg_q <= cfg_pins;
			cfg_valid <= supply_stable_in && (cfg_valid || release_edg);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			socket_present_n      <= 1'b0;
			socket_present_oe     <= 1'b1;
			mgmt_parts_present    <= 1'b0;
			mgmt_parts_present_oe <= 1'b1;
		end else begin
			socket_present_n      <= 1'b0;
			socket_present_oe     <= 1'b1;
			// floats when parts are fitted, grounded otherwise
			mgmt_parts_present    <= 1'b0;
			mgmt_parts_present_oe <= !mgmt_parts_fitted;
		end
	end

	logic [31:0] rst_len_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn) rst_len_q <= 32'h0;
		else if (held_reset) rst_len_q <= rst_len_q + 32'h1;
		else rst_len_q <= 32'h0;
	end

	property p_oe_release;
		@(posedge sys_clk) disable iff (!rstn)
		held_reset |-> ##[1:2] !bus_out_oe;
	endproperty
	a_oe_release: assert property (p_oe_release) else $error("outputs not released after reset");

	property p_inval;
		@(posedge sys_clk) disable iff (!rstn)
		held_reset |=> cache_inval && in_reset;
	endproperty
	a_inval: assert property (p_inval) else $error("no invalidate during reset");

	property p_cfg;
		@(posedge sys_clk) disable iff (!rstn)
		release_edg |=> cfg_q == $past(cfg_pins) && cfg_valid;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config not captured at release");

	property p_sock;
		@(posedge sys_clk) disable iff (!rstn)
		1'b1 |=> !socket_present_n && socket_present_oe;
	endproperty
	a_sock: assert property (p_sock) else $error("socket present not grounded");

	property p_sleep_in;
		@(posedge sys_clk) disable iff (!rstn)
		stop_grant && slp_req && !held_reset |=> sleeping && !bus_clk_en;
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");

	property p_sleep_quiet;
		@(posedge sys_clk) disable iff (!rstn)
		sleeping && slp_req |=> !snoop_ack && !intr_ack;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep answered snoop or interrupt");

	property p_sleep_out;
		@(posedge sys_clk) disable iff (!rstn)
		sleeping && !slp_req && !held_reset |=> stop_grant && bus_clk_en;
	endproperty
	a_sleep_out: assert property (p_sleep_out) else $error("sleep exit wrong");

	property p_mgmt;
		@(posedge sys_clk) disable iff (!rstn)
		1'b1 |=> mgmt_parts_present_oe == $past(!mgmt_parts_fitted) && !mgmt_parts_present;
	endproperty
	a_mgmt: assert property (p_mgmt) else $error("mgmt pin wrong");

	property p_sg;
		@(posedge sys_clk) disable iff (!rstn)
		core_clk_en && stop_req && !held_reset |=> stop_grant && !core_clk_en && bus_clk_en;
	endproperty
	a_sg: assert property (p_sg) else $error("stop grant not entered");

	property p_hold;
		@(posedge sys_clk) disable iff (!rstn)
		!supply_stable_in |=> in_reset ##1 in_reset;
	endproperty
	a_hold: assert property (p_hold) else $error("ran without supply");

	property p_sg_snoop;
		@(posedge sys_clk) disable iff (!rstn)
		stop_grant && stop_req && !slp_req && snoop_req && !held_reset |=> snoop_ack;
	endproperty
	a_sg_snoop: assert property (p_sg_snoop) else $error("stop grant dropped a snoop");

	property p_sleep_hold;
		@(posedge sys_clk) disable iff (!rstn)
		sleeping && slp_req && !held_reset |=> sleeping && !core_clk_en && !bus_clk_en;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without release");

	// a release seen before any board reset pulse must not start the core
	property p_no_early_run;
		@(posedge sys_clk) disable iff (!rstn)
		in_reset && !armed_q |=> in_reset;
	endproperty
	a_no_early_run: assert property (p_no_early_run) else $error("ran before reset pulse");

	c_boot:  cover property (@(posedge sys_clk) disable iff (!rstn) release_edg ##1 core_clk_en);
	c_sg:    cover property (@(posedge sys_clk) disable iff (!rstn) stop_grant ##1 sleeping);
	c_wake:  cover property (@(posedge sys_clk) disable iff (!rstn) sleeping ##1 stop_grant ##[1:4] core_clk_en);
	c_long:  cover property (@(posedge sys_clk) disable iff (!rstn) rst_len_q == 32'(PON_RESET_CLKS));
	c_slp_rst: cover property (@(posedge sys_clk) disable iff (!rstn) sleeping && held_reset ##1 in_reset);
endmodule : crs_top
`default_nettype wire

/* File: verification/cpu_reset_sleep_control_bench.sv */
`default_nettype none
module cpu_reset_sleep_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk;
	logic       rstn = 1'b0, pwr_cmd = 1'b0, rst_cmd = 1'b0, stop_clock_request_n = 1'b1;
	logic       sleep_request_n = 1'b1, req = 1'b1, mgmt_parts_fitted = 1'b0;
	logic [7:0] cfg_pins = 8'hA5;
	wire logic  supply_stable_in, bus_reset_n;
	logic       socket_present_n, socket_present_oe, mgmt_parts_present, mgmt_parts_present_oe;
	logic       bus_out_oe, cache_inval, in_reset, core_clk_en, bus_clk_en, stop_grant;
	logic       sleeping, snoop_ack, intr_ack, cfg_valid;
	logic [7:0] cfg_q;
	int         failures, cmp_count;
	// {0,stop_n,sleep_n,req} then {00,grant,sleep,core,bus,snoop_ack,intr_ack}
	logic [11:0] rows [5] = '{12'h70F, 12'h327, 12'h110, 12'h327, 12'h70F};
	crs_board_model #(.PULSE_CLKS(20)) board (.sys_clk, .pwr_cmd, .rst_cmd, .supply_stable_in, .bus_reset_n);
	crs_top #(.PON_RESET_CLKS(20)) uut (.sys_clk, .rstn, .supply_stable_in, .bus_reset_n,
		.stop_clock_request_n, .sleep_request_n, .snoop_req(req), .intr_req(req), .cfg_pins,
		.mgmt_parts_fitted, .socket_present_n, .socket_present_oe, .mgmt_parts_present,
		.mgmt_parts_present_oe, .bus_out_oe, .cache_inval, .in_reset, .core_clk_en, .bus_clk_en,
		.stop_grant, .sleeping, .snoop_ack, .intr_ack, .cfg_q, .cfg_valid);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	// bounded wait for the device to leave reset
	task automatic wait_run;
		for (int i = 0; i < 100 && in_reset !== 1'b0; i++)
			step(1);
		// a timeout counts here; the single closing call reports it
		chk("wait_run", 8'(in_reset), 8'h00);
	endtask : wait_run
	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		pwr_cmd <= 1'b1;
		step(5);
		chk("held", 8'(in_reset), 8'h01);
		wait_run();
		chk("cfg_q", cfg_q, 8'hA5);
		chk("oe", 8'(bus_out_oe), 8'h01);
		chk("socket", {6'h00, socket_present_n, socket_present_oe}, 8'h01);
		chk("mgmt", {6'h00, mgmt_parts_present, mgmt_parts_present_oe}, 8'h01);
		for (int r = 0; r < 5; r++) begin
			@(posedge sys_clk);
			{stop_clock_request_n, sleep_request_n, req} <= rows[r][10:8];
			step(2);
			chk("states", {2'h0, stop_grant, sleeping, core_clk_en, bus_clk_en, snoop_ack, intr_ack},
				rows[r][7:0]);
		end
		// reset arriving while asleep must still be honoured
		@(posedge sys_clk);
		{stop_clock_request_n, sleep_request_n} <= 2'h0;
		step(3);
		chk("asleep", 8'(sleeping), 8'h01);
		@(posedge sys_clk);
		rst_cmd <= 1'b1;
		@(posedge sys_clk);
		rst_cmd <= 1'b0;
		step(2);
		chk("reset", {4'h0, bus_out_oe, cache_inval, in_reset, sleeping}, 8'h06);
		@(posedge sys_clk);
		{stop_clock_request_n, sleep_request_n} <= 2'h3;
		cfg_pins <= 8'h3C;
		wait_run();
		chk("cfg_q2", {7'h00, core_clk_en} ^ cfg_q, 8'h3D);
		@(posedge sys_clk);
		pwr_cmd <= 1'b0;
		mgmt_parts_fitted <= 1'b1;
		step(3);
		chk("drop", {5'h00, in_reset, cfg_valid, mgmt_parts_present_oe}, 8'h04);
		@(posedge sys_clk);
		pwr_cmd <= 1'b1;
		wait_run();
		chk("repower", {6'h00, cfg_valid, bus_out_oe}, 8'h03);
		// local reset in mid-run: no release until the board pulses reset again
		@(posedge sys_clk);
		rstn <= 1'b0;
		step(2);
		chk("lrst", {6'h00, in_reset, cfg_valid}, 8'h02);
		@(posedge sys_clk);
		rstn <= 1'b1;
		step(4);
		chk("lrel", 8'(in_reset), 8'h01);
		@(posedge sys_clk);
		rst_cmd <= 1'b1;
		@(posedge sys_clk);
		rst_cmd <= 1'b0;
		wait_run();
		chk("relrun", {6'h00, core_clk_en, cfg_valid}, 8'h03);
		tally_and_finish();
	end
endmodule : cpu_reset_sleep_control_bench
`default_nettype wire

/* File: verification/crs_board_model.sv */
`default_nettype none
module crs_board_model #(
	parameter int unsigned PULSE_CLKS = 20
) (
	input  wire logic sys_clk,
	input  wire logic pwr_cmd,
	input  wire logic rst_cmd,
	output var  logic supply_stable_in,
	output wire logic bus_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt_q;
	// supply follows the command one clock late, so it falls and rises again each time pwr_cmd does
	always_ff @(posedge sys_clk) begin
		supply_stable_in <= pwr_cmd;
		if (!pwr_cmd || rst_cmd)
			cnt_q <= 0;
		else if (cnt_q < PULSE_CLKS)
			cnt_q <= cnt_q + 1;
	end
	// pulse scaled down, still far short of the upper limit
	assign bus_reset_n = supply_stable_in && (cnt_q >= PULSE_CLKS);
endmodule : crs_board_model
`default_nettype wire
